// *** src/scan_cfg_pkg.sv ***
package scan_cfg_pkg;

    // =====================================================================
    // Register map (byte offsets on the 8-bit register port)
    // =====================================================================
    localparam logic [7:0] OFS_OUTPUT_FORMAT = 8'h09;
    localparam logic [7:0] OFS_RESERVED_ZERO = 8'h0a;
    localparam logic [7:0] OFS_SENSOR_CONFIG = 8'h0b;
    localparam logic [7:0] OFS_TIMING_POL    = 8'h0c;
    localparam logic [7:0] OFS_PATH_STATUS   = 8'h20;

    localparam logic [7:0] RESET_OUTPUT_FORMAT = 8'h00;
    localparam logic [7:0] RESET_SENSOR_CONFIG = 8'h00;
    localparam logic [7:0] RESET_TIMING_POL    = 8'h00;
    localparam logic [7:0] RESERVED_READ       = 8'h00;

    // =====================================================================
    // Field layouts
    // =====================================================================
    // output_format_control: [7:6] unused, [5] format select, [4:3] packing, [2:0] divisor
    typedef struct packed {
        logic [1:0] unused;
        logic       output_format_select;
        logic [1:0] pixel_packing;
        logic [2:0] hdiv_code;
    } format_cfg_s;

    // sensor_configuration: [7:4] colour phase delay, [3] 600 dpi, [2] even/odd,
    // [1] double sampling, [0] positive-going video
    typedef struct packed {
        logic [3:0] colour_phase_delay;
        logic       sensor_600dpi;
        logic       even_odd_readout;
        logic       correlated_double_sampling;
        logic       video_positive;
    } sensor_cfg_s;

    // sensor_timing_polarity: one invert bit per timing line, upper bits unused
    typedef struct packed {
        logic [3:0] unused;
        logic       clamp_pulse_one;
        logic       sensor_reset_pulse;
        logic       phase_two;
        logic       phase_one;
    } timing_s;

    // Packing codes: 1, 2, 4 or 8 bits per pixel
    localparam logic [1:0] PACK_1BPP = 2'h0;
    localparam logic [1:0] PACK_2BPP = 2'h1;
    localparam logic [1:0] PACK_4BPP = 2'h2;
    localparam logic [1:0] PACK_8BPP = 2'h3;

    // Divisor in half steps, indexed by divisor code (1,1.5,2,3,4,6,8,12)
    localparam logic [4:0] HDIV_HALVES [8] = '{5'h02, 5'h03, 5'h04, 5'h06,
                                               5'h08, 5'h0c, 5'h10, 5'h18};
    localparam logic [4:0] HDIV_STEP = 5'h02;
    localparam logic [2:0] HDIV_UNITY = 3'h0;

    // Coefficient allocation limits in pixels
    localparam logic [12:0] COEF_PIXELS_300DPI = 13'h0aaa;  // 2730
    localparam logic [12:0] COEF_PIXELS_600DPI = 13'h1554;  // 5460

    // Room kept free in the byte FIFO before new pixels are taken
    localparam int FIFO_MARGIN = 4;

endpackage : scan_cfg_pkg

// *** src/scanner_pixel_format_sensor_config.sv ***
`timescale 1ns/100ps

// =========================================================================
// Byte FIFO
// =========================================================================
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       ref_clk_in,
    input  wire logic                       nrst_in,
    input  wire logic                       in_valid_in,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output logic                            in_ready_out,
    output logic                            out_valid_out,
    output logic [WIDTH-1:0]                out_data_out,
    input  wire logic                       out_ready_in,
    output logic [$clog2(DEPTH+1)-1:0]      level_out
);
    localparam int AW = $clog2(DEPTH);

    // Pointer arithmetic relies on a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        $error("byte_fifo: DEPTH must be a power of two, at least 2");

    logic [WIDTH-1:0]           mem_q [DEPTH];
    logic [AW-1:0]              wr_ptr_q;
    logic [AW-1:0]              rd_ptr_q;
    logic [$clog2(DEPTH+1)-1:0] level_q;
    wire                        push = in_valid_in && in_ready_out;
    wire                        pop  = out_valid_out && out_ready_in;

    // Flags come straight from the level, so full and empty never lie
    assign in_ready_out  = (level_q != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid_out = (level_q != '0);
    assign out_data_out  = mem_q[rd_ptr_q];
    assign level_out     = level_q;

    // Storage has no reset; only pointers and level need a defined value
    always_ff @(posedge ref_clk_in)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data_in;
    end

    // Pointers and level
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q  <= '0;
        end
        else
        begin
            wr_ptr_q <= push ? wr_ptr_q + AW'(1) : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
            level_q  <= level_q + {{($clog2(DEPTH+1)-1){1'b0}}, push}
                                - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
        end
    end

endmodule : byte_fifo

// =========================================================================
// Pixel format and sensor configuration bank
// =========================================================================
module scanner_pixel_format_sensor_config
    import scan_cfg_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                      ref_clk_in,
    input  wire logic                      nrst_in,
    // Register port
    input  wire logic [7:0]                reg_addr_in,
    input  wire logic [7:0]                reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic [7:0]                     reg_rdata_out,
    // Corrected pixel stream from the shading stage
    input  wire logic                      pix_valid_in,
    input  wire logic [11:0]               pix_data_in,
    input  wire logic                      coef_zero_in,
    output logic                           pix_ready_out,
    // Byte stream toward the host port
    output logic                           byte_valid_out,
    output logic [7:0]                     byte_data_out,
    input  wire logic                      byte_ready_in,
    // Sensor timing from the timing generator, and to the sensor pins
    input  wire scan_cfg_pkg::timing_s     timing_raw_in,
    output scan_cfg_pkg::timing_s          timing_pins_out,
    // Sensor configuration toward front end and memory controller
    output scan_cfg_pkg::sensor_cfg_s      sensor_cfg_out,
    output logic [12:0]                    coef_pixels_max_out,
    output logic [1:0]                     pixels_per_phase_out
);
    import scan_cfg_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH + 1);

    // Margin must fit the buffer, and the level must fit the status field
    if (FIFO_DEPTH < 2 * FIFO_MARGIN || LW > 5)
        $error("FIFO_DEPTH does not fit the margin or the status level field");

    // =====================================================================
    // Registers and state
    // =====================================================================
    format_cfg_s  fmt_q;
    sensor_cfg_s  sens_q;
    timing_s      pol_q;
    logic [7:0]   rdata_q;
    logic [4:0]   acc_q;
    logic [4:0]   acc_d;
    logic [7:0]   pk_q;
    logic [7:0]   pk_d;
    logic [2:0]   pk_cnt_q;
    logic [2:0]   pk_cnt_d;
    logic         wr_valid_q;
    logic         wr_valid_d;
    logic [7:0]   wr_data_q;
    logic [7:0]   wr_data_d;
    logic         hold_valid_q;
    logic         hold_valid_d;
    logic [7:0]   hold_data_q;
    logic [7:0]   hold_data_d;
    logic         pix_ready_q;
    logic         out_valid_q;
    logic [7:0]   out_data_q;
    timing_s      pins_q;
    sensor_cfg_s  sens_out_q;
    logic [12:0]  coef_max_q;
    logic [1:0]   ppp_q;
    logic [7:0]   packed_byte;

    // FIFO wiring
    logic         f_in_ready;
    logic         f_out_valid;
    logic [7:0]   f_out_data;
    logic [LW-1:0] f_level;

    // =====================================================================
    // Register decode
    // =====================================================================
    wire sel_fmt    = (reg_addr_in == OFS_OUTPUT_FORMAT);
    wire sel_rsvd   = (reg_addr_in == OFS_RESERVED_ZERO);
    wire sel_sens   = (reg_addr_in == OFS_SENSOR_CONFIG);
    wire sel_pol    = (reg_addr_in == OFS_TIMING_POL);
    wire sel_status = (reg_addr_in == OFS_PATH_STATUS);
    wire wr_fmt     = reg_wr_in && sel_fmt;
    wire wr_sens    = reg_wr_in && sel_sens;
    wire wr_pol     = reg_wr_in && sel_pol;

    // Status view of the data path
    wire [7:0] status_word = {1'b0, hold_valid_q, wr_valid_q,
                              5'(f_level)};

    // Read mux; the reserved register and unmapped addresses read zero
    wire [7:0] rd_mux =
        sel_fmt    ? 8'(fmt_q)  :
        sel_rsvd   ? RESERVED_READ :
        sel_sens   ? 8'(sens_q) :
        sel_pol    ? 8'(pol_q)  :
        sel_status ? status_word : 8'h00;

    // =====================================================================
    // Pixel front end
    // =====================================================================
    wire        pix_fire = pix_valid_in && pix_ready_q;
    // Negative-going video is flipped so bigger always means brighter
    wire [11:0] norm_px  = sens_q.video_positive ? pix_data_in : ~pix_data_in;

    // Fractional decimation in half steps handles the 1.5 and 3 divisors
    wire [4:0]  hdiv_halves = HDIV_HALVES[fmt_q.hdiv_code];
    wire [4:0]  acc_sum     = acc_q + HDIV_STEP;
    wire        keep_px     = (acc_sum >= hdiv_halves);

    // Ten-bit value after the divisor, and the gamma stage
    wire [9:0]  ten_px   = norm_px[11:2];
    // Gamma tables live outside this block; an identity map keeps the top bits
    wire [7:0]  gamma_px = ten_px[9:2];

    // Two-byte modes and the raw converter case
    wire        two_byte = fmt_q.output_format_select;
    wire        raw12    = two_byte && (fmt_q.hdiv_code == HDIV_UNITY)
                           && coef_zero_in;
    wire [7:0]  first_b  = raw12 ? {4'h0, norm_px[11:8]} : {4'h0, ten_px[9:6]};
    wire [7:0]  second_b = raw12 ? norm_px[7:0] : {ten_px[5:0], 2'b00};

    // Pixels per byte, minus one, for each packing depth
    wire [2:0]  pk_last =
        (fmt_q.pixel_packing == PACK_1BPP) ? 3'h7 :
        (fmt_q.pixel_packing == PACK_2BPP) ? 3'h3 :
        (fmt_q.pixel_packing == PACK_4BPP) ? 3'h1 : 3'h0;
    wire        pk_full  = (pk_cnt_q == pk_last);

    // Shift in the top bits of each pixel, first pixel ends up leftmost
    always_comb
    begin
        case (fmt_q.pixel_packing)
            PACK_1BPP: packed_byte = {pk_q[6:0], gamma_px[7]};
            PACK_2BPP: packed_byte = {pk_q[5:0], gamma_px[7:6]};
            PACK_4BPP: packed_byte = {pk_q[3:0], gamma_px[7:4]};
            default:   packed_byte = gamma_px;
        endcase
    end

    wire take_px   = pix_fire && keep_px;
    wire new_two   = take_px && two_byte;
    wire new_pack  = take_px && !two_byte && pk_full;
    wire push_wr   = wr_valid_q && f_in_ready;

    // =====================================================================
    // Divisor and packer next state
    // =====================================================================
    // A write to the format register restarts a partial byte and the phase
    always_comb
    begin
        acc_d    = acc_q;
        pk_d     = pk_q;
        pk_cnt_d = pk_cnt_q;
        if (wr_fmt)
        begin
            acc_d    = '0;
            pk_d     = '0;
            pk_cnt_d = '0;
        end
        else if (pix_fire)
        begin
            acc_d = keep_px ? acc_sum - hdiv_halves : acc_sum;
            if (keep_px && !two_byte)
            begin
                pk_d     = pk_full ? 8'h00 : packed_byte;
                pk_cnt_d = pk_full ? 3'h0 : pk_cnt_q + 3'h1;
            end
        end
    end

    // =====================================================================
    // Byte writer: one byte per cycle into the FIFO, second byte waits
    // =====================================================================
    always_comb
    begin
        wr_valid_d   = wr_valid_q;
        wr_data_d    = wr_data_q;
        hold_valid_d = hold_valid_q;
        hold_data_d  = hold_data_q;
        if (new_two)
        begin
            wr_valid_d   = 1'b1;
            wr_data_d    = first_b;
            hold_valid_d = 1'b1;
            hold_data_d  = second_b;
        end
        else if (new_pack)
        begin
            wr_valid_d = 1'b1;
            wr_data_d  = packed_byte;
        end
        else if (hold_valid_q && (push_wr || !wr_valid_q))
        begin
            wr_valid_d   = 1'b1;
            wr_data_d    = hold_data_q;
            hold_valid_d = 1'b0;
        end
        else if (push_wr)
            wr_valid_d = 1'b0;
    end

    // Stale-level margin covers the byte in flight plus one late pixel
    wire room_ok = (f_level <= LW'(FIFO_DEPTH - FIFO_MARGIN));
    wire ready_d = room_ok && !hold_valid_d;

    // Output stage pulls from the FIFO whenever it is empty or taken
    wire f_out_ready = !out_valid_q || byte_ready_in;
    wire load_out    = f_out_valid && f_out_ready;

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (wr_valid_q),
        .in_data_in    (wr_data_q),
        .in_ready_out  (f_in_ready),
        .out_valid_out (f_out_valid),
        .out_data_out  (f_out_data),
        .out_ready_in  (f_out_ready),
        .level_out     (f_level)
    );

    // =====================================================================
    // Configuration registers
    // =====================================================================
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            fmt_q   <= format_cfg_s'(RESET_OUTPUT_FORMAT);
            sens_q  <= sensor_cfg_s'(RESET_SENSOR_CONFIG);
            pol_q   <= timing_s'(RESET_TIMING_POL);
            rdata_q <= 8'h00;
        end
        else
        begin
            if (wr_fmt)
                fmt_q <= format_cfg_s'(reg_wdata_in);
            if (wr_sens)
                sens_q <= sensor_cfg_s'(reg_wdata_in);
            if (wr_pol)
                pol_q <= timing_s'({4'h0, reg_wdata_in[3:0]});
            rdata_q <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    // =====================================================================
    // Data path state
    // =====================================================================
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            acc_q        <= '0;
            pk_q         <= '0;
            pk_cnt_q     <= '0;
            wr_valid_q   <= 1'b0;
            wr_data_q    <= '0;
            hold_valid_q <= 1'b0;
            hold_data_q  <= '0;
            pix_ready_q  <= 1'b0;
        end
        else
        begin
            acc_q        <= acc_d;
            pk_q         <= pk_d;
            pk_cnt_q     <= pk_cnt_d;
            wr_valid_q   <= wr_valid_d;
            wr_data_q    <= wr_data_d;
            hold_valid_q <= hold_valid_d;
            hold_data_q  <= hold_data_d;
            pix_ready_q  <= ready_d;
        end
    end

    // Host-facing byte register
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end
        else if (f_out_ready)
        begin
            out_valid_q <= f_out_valid;
            out_data_q  <= load_out ? f_out_data : out_data_q;
        end
    end

    // =====================================================================
    // Sensor side outputs
    // =====================================================================
    // Registered so pins change on one edge, no glitch from the XOR
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pins_q     <= '0;
            sens_out_q <= '0;
            coef_max_q <= '0;
            ppp_q      <= '0;
        end
        else
        begin
            pins_q     <= timing_s'({4'h0, timing_raw_in[3:0] ^ pol_q[3:0]});
            sens_out_q <= sens_q;
            coef_max_q <= sens_q.sensor_600dpi ? COEF_PIXELS_600DPI
                                               : COEF_PIXELS_300DPI;
            ppp_q      <= sens_q.even_odd_readout ? 2'h2 : 2'h1;
        end
    end

    // =====================================================================
    // Output assignments
    // =====================================================================
    assign reg_rdata_out        = rdata_q;
    assign pix_ready_out        = pix_ready_q;
    assign byte_valid_out       = out_valid_q;
    assign byte_data_out        = out_data_q;
    assign timing_pins_out      = pins_q;
    assign sensor_cfg_out       = sens_out_q;
    assign coef_pixels_max_out  = coef_max_q;
    assign pixels_per_phase_out = ppp_q;

endmodule : scanner_pixel_format_sensor_config

// *** verification/scan_cfg_sva.sv ***
`timescale 1ns/100ps

// =====================================================================
// Register bank, timing pins and byte stream checks
// =====================================================================
module scan_cfg_sva
    import scan_cfg_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        nrst_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        pix_valid_in,
    input wire logic        pix_ready_out,
    input wire logic        byte_valid_out,
    input wire logic [7:0]  byte_data_out,
    input wire logic        byte_ready_in,
    input wire logic [7:0]  timing_raw_in,
    input wire logic [7:0]  timing_pins_out,
    input wire logic [7:0]  sensor_cfg_out,
    input wire logic [12:0] coef_pixels_max_out,
    input wire logic [1:0]  pixels_per_phase_out
);
    logic [7:0] fmt_q;
    logic [7:0] cfg_q;
    logic [7:0] pol_q;

    // Shadow registers; polarity keeps its low nibble
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            fmt_q <= 8'h00;
            cfg_q <= 8'h00;
            pol_q <= 8'h00;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == OFS_OUTPUT_FORMAT) fmt_q <= reg_wdata_in;
            if (reg_addr_in == OFS_SENSOR_CONFIG) cfg_q <= reg_wdata_in;
            if (reg_addr_in == OFS_TIMING_POL) pol_q <= {4'h0, reg_wdata_in[3:0]};
        end
    end

    // Expected read data; live status is left out
    wire [7:0] exp_rd = (reg_addr_in == OFS_OUTPUT_FORMAT) ? fmt_q :
                        (reg_addr_in == OFS_SENSOR_CONFIG) ? cfg_q :
                        (reg_addr_in == OFS_TIMING_POL)    ? pol_q : 8'h00;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_pix_take;
        pix_valid_in && pix_ready_out;
    endsequence
    sequence s_byte_soon;
        ##[1:20] byte_valid_out;
    endsequence

    a_reserved_zero: assert property (reg_rd_in && reg_addr_in == OFS_RESERVED_ZERO |=>
        reg_rdata_out == 8'h00) else $error("reserved register read not zero");
    a_reg_readback: assert property (reg_rd_in && reg_addr_in != OFS_PATH_STATUS |=>
        reg_rdata_out == $past(exp_rd)) else $error("register read data wrong");
    a_pins_follow: assert property ($past(nrst_in) |-> timing_pins_out ==
        {4'h0, $past(timing_raw_in[3:0] ^ pol_q[3:0])}) else $error("timing pin wrong");
    a_cfg_mirror: assert property ($past(nrst_in) |->
        sensor_cfg_out == $past(cfg_q)) else $error("sensor config copy wrong");
    a_coef_alloc: assert property ($past(nrst_in) |-> coef_pixels_max_out ==
        ($past(cfg_q[3]) ? 13'h1554 : 13'h0aaa)) else $error("coefficient limit wrong");
    a_phase_pixels: assert property ($past(nrst_in) |-> pixels_per_phase_out ==
        ($past(cfg_q[2]) ? 2'h2 : 2'h1)) else $error("pixels per phase wrong");
    a_two_byte_gap: assert property (fmt_q[5] && fmt_q[2:0] == 3'h0 ##0 s_pix_take |=>
        !pix_ready_out)
        else $error("two byte pixel taken without gap");
    a_byte_held: assert property (byte_valid_out && !byte_ready_in |=>
        byte_valid_out && $stable(byte_data_out)) else $error("byte dropped while stalled");
    a_pack_latency: assert property ((fmt_q[5:0] == 6'h18) ##0 s_pix_take |-> s_byte_soon)
        else $error("8 bit pixel produced no byte");
endmodule : scan_cfg_sva

bind scanner_pixel_format_sensor_config scan_cfg_sva i_sva (.*);

// *** verification/host_byte_sink.sv ***
`timescale 1ns/100ps

// =====================================================================
// Host port model
// =====================================================================
module host_byte_sink (
    input  wire logic       ref_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       stall_in,
    input  wire logic       byte_valid_in,
    input  wire logic [7:0] byte_data_in,
    output logic            byte_ready_out
);
    logic [7:0] rx_q[$];

    // Never ready in reset
    assign byte_ready_out = nrst_in && !stall_in;

    // Accepted bytes kept in arrival order
    always @(posedge ref_clk_in)
    begin
        if (byte_valid_in && byte_ready_out)
            rx_q.push_back(byte_data_in);
    end
endmodule : host_byte_sink

// *** verification/scanner_pixel_format_sensor_config_test.sv ***
`timescale 1ns/100ps

`define CHK(a, e) \
    begin \
        n_checks++; \
        if ((a) !== (e)) \
        begin \
            err_count++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); \
        end \
    end

module scanner_pixel_format_sensor_config_test;
    import scan_cfg_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [7:0]  reg_rdata_out;
    logic        pix_valid_in = 1'b0;
    logic [11:0] pix_data_in = 12'h000;
    logic        coef_zero_in = 1'b0;
    logic        pix_ready_out;
    logic        byte_valid_out;
    logic        byte_ready_in;
    logic        stall = 1'b0;
    logic [7:0]  byte_data_out;
    timing_s     timing_raw_in = 8'h00;
    timing_s     timing_pins_out;
    sensor_cfg_s sensor_cfg_out;
    logic [12:0] coef_pixels_max_out;
    logic [1:0]  pixels_per_phase_out;
    logic [7:0]  acc;
    logic [7:0]  g[8] = '{8'h80, 8'h40, 8'hc0, 8'h00, 8'hff, 8'h7f, 8'h91, 8'h2e};
    int          err_count = 0;
    int          n_checks = 0;
    int          nb;

    always #25 ref_clk_in = ~ref_clk_in;

    scanner_pixel_format_sensor_config #(.FIFO_DEPTH(16)) i_dut (.*);

    host_byte_sink i_host (.ref_clk_in, .nrst_in, .stall_in(stall),
        .byte_valid_in(byte_valid_out), .byte_data_in(byte_data_out),
        .byte_ready_out(byte_ready_in));

    // =================================================================
    // Access tasks
    // =================================================================
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK(reg_rdata_out, e)
    endtask : rdc

    // Call after a rising edge; returns after the taking edge
    task automatic px(input logic [11:0] p);
        pix_valid_in <= 1'b1;
        pix_data_in <= p;
        @(negedge ref_clk_in);
        while (pix_ready_out !== 1'b1)
        begin
            @(negedge ref_clk_in);
        end
        @(posedge ref_clk_in);
    endtask : px

    // Next byte seen by the host, bounded wait
    task automatic gb(input logic [7:0] e);
        int k = 0;
        while (i_host.rx_q.size() == 0 && k < 400)
        begin
            @(negedge ref_clk_in);
            k++;
        end
        acc = (i_host.rx_q.size() > 0) ? i_host.rx_q.pop_front() : 8'hxx;
        `CHK(acc, e)
    endtask : gb

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // Watchdog: the sequence needs a few hundred cycles
    initial
    begin
        #(50 * 20000);
        err_count++;
        finish_test();
    end

    // =================================================================
    // Test sequence
    // =================================================================
    initial
    begin
        repeat (8) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        rdc(OFS_OUTPUT_FORMAT, 8'h00);
        rdc(OFS_SENSOR_CONFIG, 8'h00);
        wr(OFS_RESERVED_ZERO, 8'h00);
        rdc(OFS_RESERVED_ZERO, 8'h00);
        wr(8'h33, 8'ha5);
        rdc(8'h33, 8'h00);
        wr(OFS_TIMING_POL, 8'hf3);
        timing_raw_in <= 8'h05;
        rdc(OFS_TIMING_POL, 8'h03);
        `CHK(timing_pins_out, 8'h06)
        wr(OFS_SENSOR_CONFIG, 8'hfc);
        rdc(OFS_SENSOR_CONFIG, 8'hfc);
        `CHK(sensor_cfg_out, 8'hfc)
        `CHK(coef_pixels_max_out, 13'h1554)
        `CHK(pixels_per_phase_out, 2'h2)
        wr(OFS_SENSOR_CONFIG, 8'h01);
        rdc(OFS_SENSOR_CONFIG, 8'h01);
        `CHK(coef_pixels_max_out, 13'h0aaa)
        `CHK(pixels_per_phase_out, 2'h1)
        // Every packing depth, MSB first
        for (int c = 0; c < 4; c++)
        begin
            wr(OFS_OUTPUT_FORMAT, {3'h0, c[1:0], 3'h0});
            for (int i = 0; i < 8; i++) px({g[i], 4'h0});
            pix_valid_in <= 1'b0;
            nb = 0;
            for (int i = 0; i < 8; i++)
            begin
                acc = (acc << (1 << c)) | (g[i] >> (8 - (1 << c)));
                nb += 1 << c;
                if (nb == 8) gb(acc);
                if (nb == 8) nb = 0;
            end
        end
        // Negative-going video is inverted
        wr(OFS_SENSOR_CONFIG, 8'h00);
        wr(OFS_OUTPUT_FORMAT, 8'h18);
        px(12'h120);
        pix_valid_in <= 1'b0;
        gb(8'hed);
        // 10-bit, then raw 12-bit two-byte pixels
        wr(OFS_SENSOR_CONFIG, 8'h01);
        wr(OFS_OUTPUT_FORMAT, 8'h20);
        for (int z = 0; z < 2; z++)
        begin
            @(posedge ref_clk_in);
            coef_zero_in <= z[0];
            px(12'hb5f);
            px(12'h3a7);
            pix_valid_in <= 1'b0;
            coef_zero_in <= 1'b0;
            gb(8'h0b);
            gb(z ? 8'h5f : 8'h5c);
            gb(8'h03);
            gb(z ? 8'ha7 : 8'ha4);
        end
        // Divisors 2 and 3
        for (int d = 2; d < 4; d++)
        begin
            wr(OFS_OUTPUT_FORMAT, 8'h18 | d[7:0]);
            for (int i = 0; i < 6; i++) px({g[i], 4'h0});
            pix_valid_in <= 1'b0;
            for (int i = d - 1; i < 6; i += d) gb(g[i]);
        end
        // Stalled host fills the buffer, then drains it
        wr(OFS_OUTPUT_FORMAT, 8'h18);
        stall <= 1'b1;
        fork
            for (int i = 0; i < 20; i++) px({i[7:0], 4'h0});
            begin
                repeat (100) @(negedge ref_clk_in);
                `CHK(pix_ready_out, 1'b0)
                @(posedge ref_clk_in);
                stall <= 1'b0;
            end
        join
        pix_valid_in <= 1'b0;
        for (int i = 0; i < 20; i++) gb(i[7:0]);
        repeat (4) @(negedge ref_clk_in);
        `CHK(byte_valid_out, 1'b0)
        rdc(OFS_PATH_STATUS, 8'h00);
        finish_test();
    end
endmodule : scanner_pixel_format_sensor_config_test
